// file: rtcrm_pkg.sv
`default_nettype none
package rtcrm_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] RTCRM_SUBSECOND_COUNT   = 4'h0;
	localparam logic [3:0] RTCRM_SECONDS_COUNT     = 4'h1;
	localparam logic [3:0] RTCRM_MINUTES_COUNT     = 4'h2;
	localparam logic [3:0] RTCRM_HOURS_COUNT       = 4'h3;
	localparam logic [3:0] RTCRM_WEEKDAY_FREQ_SEL  = 4'h4;
	localparam logic [3:0] RTCRM_DATE_COUNT        = 4'h5;
	localparam logic [3:0] RTCRM_CENTURY_MONTH     = 4'h6;
	localparam logic [3:0] RTCRM_YEAR_COUNT        = 4'h7;
	localparam logic [3:0] RTCRM_CALIBRATION_CTRL  = 4'h8;
	localparam logic [3:0] RTCRM_WATCHDOG_CTRL     = 4'h9;
	localparam logic [3:0] RTCRM_ALARM_MONTH_CTRL  = 4'ha;
	localparam logic [3:0] RTCRM_ALARM_DATE        = 4'hb;
	localparam logic [3:0] RTCRM_ALARM_HOUR        = 4'hc;
	localparam logic [3:0] RTCRM_ALARM_MINUTE      = 4'hd;
	localparam logic [3:0] RTCRM_ALARM_SECOND      = 4'he;
	localparam logic [3:0] RTCRM_FLAG_STATUS       = 4'hf;
	localparam int         RTCRM_NUM_REGS          = 16;
	localparam int         RTCRM_NUM_CLOCK         = 8;
	localparam int         RTCRM_NUM_CTRL          = 7;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int RTCRM_OSC_HALT_BIT      = 7;
	localparam int RTCRM_OSC_FAIL_IE_BIT   = 7;
	localparam int RTCRM_SQW_SEL_LSB       = 4;
	localparam int RTCRM_CENTURY_LSB       = 6;
	localparam int RTCRM_OUT_LEVEL_BIT     = 7;
	localparam int RTCRM_CAL_SIGN_BIT      = 5;
	localparam int RTCRM_WD_RES_MSB_BIT    = 7;
	localparam int RTCRM_WD_MULT_LSB       = 2;
	localparam int RTCRM_ALARM_IRQ_EN_BIT  = 7;
	localparam int RTCRM_SQW_EN_BIT        = 6;
	localparam int RTCRM_REPEAT_HI_BIT     = 7;
	localparam int RTCRM_REPEAT_LO_BIT     = 6;
	localparam int RTCRM_WD_FLAG_BIT       = 7;
	localparam int RTCRM_ALARM_FLAG_BIT    = 6;
	localparam int RTCRM_OSC_FAIL_BIT      = 2;
	// ---------------------------------------------------------------
	// Storable bits per register and reset value
	// ---------------------------------------------------------------
	localparam logic [15:0][7:0] RTCRM_WRITE_MASK = {
		8'h00, 8'hff, 8'hff, 8'hbf, 8'hff, 8'hdf, 8'hff, 8'hbf,
		8'hff, 8'hdf, 8'h3f, 8'hf7, 8'h3f, 8'hff, 8'hff, 8'h00};
	localparam logic [7:0] RTCRM_RESET_BYTE = 8'h00;
	localparam logic [7:0] RTCRM_SUBSEC_ZERO = 8'h00;
endpackage : rtcrm_pkg
`default_nettype wire

// file: rtcrm_register_map.sv
`timescale 1ns/1ps
`default_nettype none
module rtcrm_register_map
	import rtcrm_pkg::*;
#(
	parameter int NUM_REGS = RTCRM_NUM_REGS
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	input  wire logic        bus_stop,
	input  wire logic        count_valid,
	input  wire logic [63:0] count_values,
	input  wire logic        refresh_tick,
	input  wire logic        watchdog_expired_flag,
	input  wire logic        alarm_hit_flag,
	input  wire logic        osc_fail_flag,
	output logic      [7:0]  reg_rdata,
	output logic      [63:0] internal_time,
	output logic             divider_reset,
	output logic             irq_out,
	output logic             oscillator_halt,
	output logic             osc_fail_irq_enable,
	output logic      [3:0]  sqw_freq_select,
	output logic      [1:0]  century_bits,
	output logic             output_level,
	output logic             cal_sign,
	output logic      [4:0]  cal_magnitude,
	output logic      [4:0]  watchdog_multiplier,
	output logic      [2:0]  watchdog_resolution,
	output logic      [4:0]  alarm_repeat_select,
	output logic             alarm_irq_enable,
	output logic             square_wave_enable,
	output logic      [7:0]  alarm_month,
	output logic      [7:0]  alarm_date,
	output logic      [7:0]  alarm_hour,
	output logic      [7:0]  alarm_minute,
	output logic      [7:0]  alarm_second
);
	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (NUM_REGS != RTCRM_NUM_REGS) begin : g_bad_regs
		$error("rtcrm_register_map serves exactly sixteen registers");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0][7:0] user;
		logic [7:0][7:0] internal;
		logic [6:0][7:0] ctrl;
		logic            halt;
		logic [7:0]      rdata;
		logic            div_rst;
		logic            irq;
	} rtcrm_state_s;

	rtcrm_state_s q;
	rtcrm_state_s next_q;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Address falls in the clock range 00h..07h
	function automatic logic rtcrm_is_clock(input logic [3:0] addr);
		rtcrm_is_clock = (addr[3] == 1'b0);
	endfunction : rtcrm_is_clock

	// Index of a control register 08h..0Eh
	function automatic logic [2:0] rtcrm_ctrl_idx(input logic [3:0] addr);
		rtcrm_ctrl_idx = addr[2:0];
	endfunction : rtcrm_ctrl_idx

	// Flags byte built from live status
	function automatic logic [7:0] rtcrm_flags(input logic wd_flag, input logic alarm_flag, input logic osc_flag);
		logic [7:0] f;
		f = 8'h00;
		f[RTCRM_WD_FLAG_BIT] = wd_flag;
		f[RTCRM_ALARM_FLAG_BIT] = alarm_flag;
		f[RTCRM_OSC_FAIL_BIT] = osc_flag;
		rtcrm_flags = f;
	endfunction : rtcrm_flags

	logic       wr_clock;
	logic       wr_ctrl;
	logic [7:0] wr_byte;

	// Write decode; fixed-zero bits are not stored
	always_comb begin
		wr_clock = reg_wr && rtcrm_is_clock(reg_addr);
		wr_ctrl = reg_wr && !rtcrm_is_clock(reg_addr) && (reg_addr != RTCRM_FLAG_STATUS);
		wr_byte = reg_wdata & RTCRM_WRITE_MASK[reg_addr];
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_q = q;
		next_q.div_rst = 1'b0;
		// Counter core delivers incremented internal values
		if (count_valid) begin
			next_q.internal = count_values;
		end
		// Simultaneous transfer unless a clock read holds it off
		if (refresh_tick && !q.halt) begin
			next_q.user = q.internal;
		end
		// Clock write sets both copies and restarts the divider
		if (wr_clock) begin
			next_q.user[reg_addr[2:0]] = wr_byte;
			next_q.internal[reg_addr[2:0]] = wr_byte;
			next_q.user[0] = RTCRM_SUBSEC_ZERO;
			next_q.internal[0] = RTCRM_SUBSEC_ZERO;
			next_q.div_rst = 1'b1;
		end
		// Control, calibration and alarm registers stored as written
		if (wr_ctrl) begin
			next_q.ctrl[rtcrm_ctrl_idx(reg_addr)] = wr_byte;
		end
		// Read data captured on the read strobe
		if (reg_rd) begin
			if (rtcrm_is_clock(reg_addr)) begin
				next_q.rdata = q.user[reg_addr[2:0]];
			end else if (reg_addr == RTCRM_FLAG_STATUS) begin
				next_q.rdata = rtcrm_flags(watchdog_expired_flag, alarm_hit_flag, osc_fail_flag);
			end else begin
				next_q.rdata = q.ctrl[rtcrm_ctrl_idx(reg_addr)];
			end
		end
		// Halt tracking; a new clock read wins over stop
		if (reg_rd && rtcrm_is_clock(reg_addr)) begin
			next_q.halt = 1'b1;
		end else if (bus_stop || !rtcrm_is_clock(reg_addr)) begin
			next_q.halt = 1'b0;
		end
		// Interrupt output from enabled flags
		next_q.irq = (q.user[RTCRM_MINUTES_COUNT[2:0]][RTCRM_OSC_FAIL_IE_BIT] && osc_fail_flag)
			|| (q.ctrl[RTCRM_ALARM_MONTH_CTRL[2:0]][RTCRM_ALARM_IRQ_EN_BIT] && alarm_hit_flag);
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.rdata <= RTCRM_RESET_BYTE;
		end else begin
			q <= next_q;
		end
	end

	// ---------------------------------------------------------------
	// Outputs straight from state
	// ---------------------------------------------------------------
	assign reg_rdata = q.rdata;
	assign internal_time = q.internal;
	assign divider_reset = q.div_rst;
	assign irq_out = q.irq;
	// Clock-register control bits
	assign oscillator_halt = q.user[RTCRM_SECONDS_COUNT[2:0]][RTCRM_OSC_HALT_BIT];
	assign osc_fail_irq_enable = q.user[RTCRM_MINUTES_COUNT[2:0]][RTCRM_OSC_FAIL_IE_BIT];
	assign sqw_freq_select = q.user[RTCRM_WEEKDAY_FREQ_SEL[2:0]][RTCRM_SQW_SEL_LSB +: 4];
	assign century_bits = q.user[RTCRM_CENTURY_MONTH[2:0]][RTCRM_CENTURY_LSB +: 2];
	// Calibration fields, binary
	assign output_level = q.ctrl[0][RTCRM_OUT_LEVEL_BIT];
	assign cal_sign = q.ctrl[0][RTCRM_CAL_SIGN_BIT];
	assign cal_magnitude = q.ctrl[0][4:0];
	// Watchdog fields, binary
	assign watchdog_multiplier = q.ctrl[1][RTCRM_WD_MULT_LSB +: 5];
	assign watchdog_resolution = {q.ctrl[1][RTCRM_WD_RES_MSB_BIT], q.ctrl[1][1:0]};
	// Alarm repeat bits, highest number first
	assign alarm_repeat_select = {q.ctrl[3][RTCRM_REPEAT_LO_BIT], q.ctrl[3][RTCRM_REPEAT_HI_BIT],
		q.ctrl[4][RTCRM_REPEAT_HI_BIT], q.ctrl[5][RTCRM_REPEAT_HI_BIT], q.ctrl[6][RTCRM_REPEAT_HI_BIT]};
	assign alarm_irq_enable = q.ctrl[2][RTCRM_ALARM_IRQ_EN_BIT];
	assign square_wave_enable = q.ctrl[2][RTCRM_SQW_EN_BIT];
	// Alarm BCD values for the match logic
	assign alarm_month = q.ctrl[2];
	assign alarm_date = q.ctrl[3];
	assign alarm_hour = q.ctrl[4];
	assign alarm_minute = q.ctrl[5];
	assign alarm_second = q.ctrl[6];

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking core_edge @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_div_reset;
		wr_clock |=> divider_reset ##1 (divider_reset == $past(wr_clock));
	endproperty
	a_div_reset: assert property (p_div_reset) else $error("divider reset missing after clock write");

	property p_no_div_reset;
		!wr_clock |=> !divider_reset;
	endproperty
	a_no_div_reset: assert property (p_no_div_reset) else $error("spurious divider reset");

	property p_subsec_zero;
		wr_clock |=> (q.user[0] == 8'h00) && (q.internal[0] == 8'h00);
	endproperty
	a_subsec_zero: assert property (p_subsec_zero) else $error("subseconds not cleared by clock write");

	property p_hold_while_halted;
		q.halt && !wr_clock |=> $stable(q.user);
	endproperty
	a_hold_while_halted: assert property (p_hold_while_halted) else $error("user copy changed while halted");

	property p_refresh;
		refresh_tick && !q.halt && !wr_clock |=> q.user == $past(q.internal);
	endproperty
	a_refresh: assert property (p_refresh) else $error("user copy not refreshed");

	property p_resume;
		(bus_stop || !rtcrm_is_clock(reg_addr)) && !(reg_rd && rtcrm_is_clock(reg_addr)) |=> !q.halt;
	endproperty
	a_resume: assert property (p_resume) else $error("refresh did not resume");

	property p_flags_read;
		reg_rd && (reg_addr == RTCRM_FLAG_STATUS) |=>
			reg_rdata == {$past(watchdog_expired_flag), $past(alarm_hit_flag), 3'b000, $past(osc_fail_flag), 2'b00};
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flags byte wrong");

	property p_flags_ro;
		reg_wr && (reg_addr == RTCRM_FLAG_STATUS) |=> $stable(q.ctrl)
			&& (q.user == $past((refresh_tick && !q.halt) ? q.internal : q.user));
	endproperty
	a_flags_ro: assert property (p_flags_ro) else $error("flags write changed state");

	property p_osc_irq;
		osc_fail_irq_enable && osc_fail_flag |=> irq_out;
	endproperty
	a_osc_irq: assert property (p_osc_irq) else $error("oscillator-fail interrupt missing");

	property p_alarm_irq;
		alarm_irq_enable && alarm_hit_flag |=> irq_out;
	endproperty
	a_alarm_irq: assert property (p_alarm_irq) else $error("alarm interrupt missing");

	property p_no_irq;
		!(osc_fail_irq_enable && osc_fail_flag) && !(alarm_irq_enable && alarm_hit_flag) |=> !irq_out;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("interrupt without enabled flag");

	property p_osc_halt;
		reg_wr && (reg_addr == RTCRM_SECONDS_COUNT) |=> oscillator_halt == $past(reg_wdata[7]);
	endproperty
	a_osc_halt: assert property (p_osc_halt) else $error("oscillator halt bit not taken");

	property p_sqw_en;
		reg_wr && (reg_addr == RTCRM_ALARM_MONTH_CTRL) |=> square_wave_enable == $past(reg_wdata[6]);
	endproperty
	a_sqw_en: assert property (p_sqw_en) else $error("square wave enable not taken");

	property p_cal_d6;
		1'b1 |-> q.ctrl[0][6] == 1'b0;
	endproperty
	a_cal_d6: assert property (p_cal_d6) else $error("calibration D6 not zero");

	// Read path: captured data, hold and halt
	property p_clock_read;
		reg_rd && rtcrm_is_clock(reg_addr) |=> reg_rdata == $past(q.user[reg_addr[2:0]]);
	endproperty
	a_clock_read: assert property (p_clock_read) else $error("clock read did not return user copy");

	property p_ctrl_read;
		reg_rd && !rtcrm_is_clock(reg_addr) && (reg_addr != RTCRM_FLAG_STATUS) |=>
			reg_rdata == $past(q.ctrl[reg_addr[2:0]]);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read returned wrong byte");

	property p_rdata_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

	property p_flags_clean;
		reg_rd && (reg_addr == RTCRM_FLAG_STATUS) |=> (reg_rdata & 8'h3b) == 8'h00;
	endproperty
	a_flags_clean: assert property (p_flags_clean) else $error("flags fixed-zero bits set");

	property p_halt_set;
		reg_rd && rtcrm_is_clock(reg_addr) |=> q.halt;
	endproperty
	a_halt_set: assert property (p_halt_set) else $error("clock read did not hold refresh");

	property p_halt_only_read;
		!reg_rd && !q.halt |=> !q.halt;
	endproperty
	a_halt_only_read: assert property (p_halt_only_read) else $error("refresh held without a read");

	// Write path: both copies and field placement
	property p_internal_load;
		count_valid && !wr_clock |=> internal_time == $past(count_values);
	endproperty
	a_internal_load: assert property (p_internal_load) else $error("internal copy not loaded");

	property p_clock_write;
		wr_clock && (reg_addr != RTCRM_SUBSECOND_COUNT) |=>
			(q.user[$past(reg_addr[2:0])] == $past(wr_byte))
			&& (q.internal[$past(reg_addr[2:0])] == $past(wr_byte));
	endproperty
	a_clock_write: assert property (p_clock_write) else $error("clock write missed a copy");

	property p_ctrl_write;
		wr_ctrl |=> q.ctrl[$past(reg_addr[2:0])] == $past(wr_byte);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

	property p_osc_irq_en;
		reg_wr && (reg_addr == RTCRM_MINUTES_COUNT) |=> osc_fail_irq_enable == $past(reg_wdata[7]);
	endproperty
	a_osc_irq_en: assert property (p_osc_irq_en) else $error("oscillator-fail enable not taken");

	property p_weekday_sel;
		reg_wr && (reg_addr == RTCRM_WEEKDAY_FREQ_SEL) |=> (sqw_freq_select == $past(reg_wdata[7:4]))
			&& (q.user[4][3:0] == {1'b0, $past(reg_wdata[2:0])});
	endproperty
	a_weekday_sel: assert property (p_weekday_sel) else $error("weekday or frequency select wrong");

	property p_century;
		reg_wr && (reg_addr == RTCRM_CENTURY_MONTH) |=> century_bits == $past(reg_wdata[7:6]);
	endproperty
	a_century: assert property (p_century) else $error("century bits not taken");

	property p_wd_fields;
		reg_wr && (reg_addr == RTCRM_WATCHDOG_CTRL) |=> (watchdog_multiplier == $past(reg_wdata[6:2]))
			&& (watchdog_resolution == {$past(reg_wdata[7]), $past(reg_wdata[1:0])});
	endproperty
	a_wd_fields: assert property (p_wd_fields) else $error("watchdog fields not taken");

	property p_repeat_date;
		reg_wr && (reg_addr == RTCRM_ALARM_DATE) |=>
			alarm_repeat_select[4:3] == {$past(reg_wdata[6]), $past(reg_wdata[7])};
	endproperty
	a_repeat_date: assert property (p_repeat_date) else $error("alarm date repeat bits wrong");

	property p_alarm_en;
		reg_wr && (reg_addr == RTCRM_ALARM_MONTH_CTRL) |=> alarm_irq_enable == $past(reg_wdata[7]);
	endproperty
	a_alarm_en: assert property (p_alarm_en) else $error("alarm interrupt enable not taken");

	property p_cal_fields;
		reg_wr && (reg_addr == RTCRM_CALIBRATION_CTRL) |=> (output_level == $past(reg_wdata[7]))
			&& (cal_sign == $past(reg_wdata[5])) && (cal_magnitude == $past(reg_wdata[4:0]));
	endproperty
	a_cal_fields: assert property (p_cal_fields) else $error("calibration fields not taken");

endmodule : rtcrm_register_map
`default_nettype wire

// file: rtcrm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtcrm_host_model (
	input  wire logic       core_clk,
	output logic      [3:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	output logic            bus_stop,
	input  wire logic [7:0] reg_rdata
);
	// Storable bits per address; everything else is a fixed zero
	localparam logic [15:0][7:0] ZM = {8'h00, 8'hff, 8'hff, 8'hbf, 8'hff, 8'hdf, 8'hff, 8'hbf,
		8'hff, 8'hdf, 8'h3f, 8'hf7, 8'h3f, 8'hff, 8'hff, 8'h00};
	// Idle bus engine
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		{reg_wr, reg_rd, bus_stop} = 3'b000;
	end
	// One byte write; raw lets a scenario break the zero-bit habit
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic raw);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = raw ? d : (d & ZM[a]);
		reg_wr = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata;
	endtask : wr
	// One byte read; data is taken once the strobe edge has passed
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
	// Pointer move without a transfer
	task automatic point(input logic [3:0] a);
		@(posedge core_clk);
		#1;
		reg_addr = a;
	endtask : point
	// Stop condition pulse
	task automatic stop();
		@(posedge core_clk);
		#1;
		bus_stop = 1'b1;
		@(posedge core_clk);
		#1;
		bus_stop = 1'b0;
	endtask : stop
endmodule : rtcrm_host_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        core_clk, rst_n, reg_wr, reg_rd, bus_stop, count_valid, refresh_tick, divider_reset, irq_out;
	logic        watchdog_expired_flag, alarm_hit_flag, osc_fail_flag, oscillator_halt, osc_fail_irq_enable;
	logic        output_level, cal_sign, alarm_irq_enable, square_wave_enable;
	logic [1:0]  century_bits;
	logic [2:0]  watchdog_resolution;
	logic [3:0]  reg_addr, sqw_freq_select;
	logic [4:0]  cal_magnitude, watchdog_multiplier, alarm_repeat_select;
	logic [7:0]  reg_wdata, reg_rdata, alarm_month, alarm_date, alarm_hour, alarm_minute, alarm_second, rdat;
	logic [63:0] count_values, internal_time;
	int          n_mismatch = 0, check_count = 0, cycles = 0;
	// Block and host
	rtcrm_register_map rtcrm_register_map_inst (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.bus_stop, .count_valid, .count_values, .refresh_tick, .watchdog_expired_flag, .alarm_hit_flag,
		.osc_fail_flag, .reg_rdata, .internal_time, .divider_reset, .irq_out, .oscillator_halt,
		.osc_fail_irq_enable, .sqw_freq_select, .century_bits, .output_level, .cal_sign, .cal_magnitude,
		.watchdog_multiplier, .watchdog_resolution, .alarm_repeat_select, .alarm_irq_enable,
		.square_wave_enable, .alarm_month, .alarm_date, .alarm_hour, .alarm_minute, .alarm_second);
	rtcrm_host_model host_inst (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .bus_stop, .reg_rdata);
	// 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles >= 3000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	// One-cycle pulse of new counts or of the refresh tick
	task automatic feed(input logic [63:0] v, input logic tk);
		@(posedge core_clk);
		#1;
		if (tk) refresh_tick = 1'b1;
		else begin
			count_valid = 1'b1;
			count_values = v;
		end
		@(posedge core_clk);
		#1;
		{refresh_tick, count_valid} = 2'b00;
		count_values = ~count_values;
	endtask : feed
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : idle
	task automatic t_map();
		for (int a = 0; a < 16; a++) begin
			host_inst.wr(a[3:0], 8'hff, 1'b1);
			chk("divider_reset", {63'h0, a < 8}, {63'h0, divider_reset});
			host_inst.rd(a[3:0], rdat);
			chk("divider_reset gone", 64'h0, {63'h0, divider_reset});
			chk("readback", {56'h0, host_inst.ZM[a]}, {56'h0, rdat});
		end
	endtask : t_map
	task automatic t_fields();
		logic [3:0] fa [9];
		logic [7:0] fd [9];
		fa = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'he};
		fd = '{8'h80, 8'h80, 8'h51, 8'h81, 8'ha5, 8'h86, 8'hc1, 8'h41, 8'h80};
		for (int i = 0; i < 9; i++) host_inst.wr(fa[i], fd[i], 1'b0);
		chk("fields", {1'b1, 1'b1, 4'h5, 2'h2, 1'b1, 1'b1, 5'h05, 5'h01, 3'h6, 5'h17, 1'b1, 1'b1},
			{oscillator_halt, osc_fail_irq_enable, sqw_freq_select, century_bits, output_level, cal_sign,
			cal_magnitude, watchdog_multiplier, watchdog_resolution, alarm_repeat_select, alarm_irq_enable,
			square_wave_enable});
		chk("alarm bytes", 40'hc1_41_bf_ff_80,
			{alarm_month, alarm_date, alarm_hour, alarm_minute, alarm_second});
	endtask : t_fields
	task automatic t_flags();
		{watchdog_expired_flag, alarm_hit_flag, osc_fail_flag} = 3'b101;
		host_inst.rd(4'hf, rdat);
		chk("flags wd osc", 64'h84, {56'h0, rdat});
		{watchdog_expired_flag, alarm_hit_flag, osc_fail_flag} = 3'b011;
		host_inst.wr(4'hf, 8'hff, 1'b1);
		host_inst.rd(4'hf, rdat);
		chk("flags alarm osc", 64'h44, {56'h0, rdat});
	endtask : t_flags
	task automatic t_irq();
		host_inst.wr(4'h2, 8'h00, 1'b0);
		host_inst.wr(4'ha, 8'h00, 1'b0);
		idle(2);
		chk("irq masked", 64'h0, {63'h0, irq_out});
		host_inst.wr(4'h2, 8'h80, 1'b0);
		idle(1);
		chk("irq osc fail", 64'h1, {63'h0, irq_out});
		host_inst.wr(4'h2, 8'h00, 1'b0);
		host_inst.wr(4'ha, 8'h80, 1'b0);
		idle(1);
		chk("irq alarm", 64'h1, {63'h0, irq_out});
		alarm_hit_flag = 1'b0;
		idle(2);
		chk("irq alarm gone", 64'h0, {63'h0, irq_out});
	endtask : t_irq
	task automatic t_refresh();
		host_inst.wr(4'h1, 8'h00, 1'b0);
		chk("halt off", 64'h0, {63'h0, oscillator_halt});
		host_inst.point(4'h8);
		feed(64'h24_11_15_03_21_45_30_12, 1'b0);
		chk("internal", 64'h24_11_15_03_21_45_30_12, internal_time);
		feed(64'h0, 1'b1);
		host_inst.rd(4'h3, rdat);
		chk("refreshed", 64'h21, {56'h0, rdat});
		feed(64'h24_11_15_03_22_46_31_13, 1'b0);
		feed(64'h0, 1'b1);
		host_inst.rd(4'h3, rdat);
		chk("held while reading", 64'h21, {56'h0, rdat});
		host_inst.stop();
		feed(64'h0, 1'b1);
		host_inst.rd(4'h3, rdat);
		chk("resumed by stop", 64'h22, {56'h0, rdat});
		feed(64'h24_11_15_03_23_47_32_14, 1'b0);
		host_inst.point(4'h9);
		feed(64'h0, 1'b1);
		host_inst.rd(4'h3, rdat);
		chk("resumed by pointer", 64'h23, {56'h0, rdat});
		host_inst.wr(4'h5, 8'h12, 1'b0);
		host_inst.rd(4'h0, rdat);
		chk("subsecond cleared", 64'h0, {56'h0, rdat});
	endtask : t_refresh
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{count_valid, refresh_tick, watchdog_expired_flag, alarm_hit_flag, osc_fail_flag} = 5'b00000;
		count_values = 64'h0;
		repeat (3) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		chk("reset outputs", 64'h0, {reg_rdata, divider_reset, irq_out, oscillator_halt, internal_time[31:0]});
		t_map();
		t_fields();
		t_flags();
		t_irq();
		t_refresh();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
